//--- fesm_sequencer.sv
// command sequencer for sector erase, unsecure, backdoor key, user margin
`timescale 1ns/1ps
`include "fesm_cfg.svh"
module fesm_sequencer
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  // command object loading
  input  wire logic                     param_wr,
  input  wire logic [2:0]               command_object_index,
  input  wire fesm_pkg::fesm_word_t     command_object_word,
  input  wire logic                     launch,
  // configuration
  input  wire logic                     mode_allows_cmd,
  input  wire logic [1:0]               backdoor_key_enable_field,
  input  wire logic [63:0]              stored_key,
  input  wire logic                     sector_protected,
  input  wire logic                     any_protected,
  input  wire logic                     secure_at_reset,
  // array engine
  output fesm_pkg::fesm_array_req_s     array_req,
  input  wire fesm_pkg::fesm_array_resp_s array_resp,
  // status
  output logic                          command_complete_flag,
  output fesm_pkg::fesm_status_s        flash_status_reg,
  output logic                          secured,
  output logic                          backdoor_locked,
  output fesm_pkg::fesm_level_e         pflash_level,
  output fesm_pkg::fesm_level_e         dflash_level
);
  import fesm_pkg::*;

  typedef enum logic [4:0] {
    FESM_IDLE  = 5'b00001,
    FESM_FETCH = 5'b00010,
    FESM_CHECK = 5'b00100,
    FESM_ARRAY = 5'b01000,
    FESM_DONE  = 5'b10000
  } fesm_state_e;

  fesm_state_e  state_reg;
  logic [2:0]   index_reg;
  logic [2:0]   rd_idx_reg;
  logic [2:0]   fetch_cnt_reg;
  fesm_word_t   rd_data;
  fesm_word_t   w_reg [0:5];
  logic         sync1_reg;
  logic         sync2_reg;
  logic         armed_reg;
  logic         key_ok;
  logic         acc_err;
  logic         prot_err;
  logic [7:0]   cmd;
  logic [1:0]   blk;

  // ====================================================
  // secure strap capture
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= secure_at_reset;
      sync2_reg <= sync1_reg;
    end
  end

  // ====================================================
  // parameter storage
  fesm_param_mem u_mem
  (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wr_en   (param_wr && command_complete_flag),
    .wr_idx  (command_object_index),
    .wr_data (command_object_word),
    .rd_idx  (rd_idx_reg),
    .rd_data (rd_data)
  );

  function automatic logic margin_valid(input fesm_word_t w);
    margin_valid = (w == `FESM_MARGIN_NORMAL) ||
                   (w == `FESM_MARGIN_USER1) ||
                   (w == `FESM_MARGIN_USER0);
  endfunction

  function automatic fesm_level_e margin_level(input fesm_word_t w);
    case (w)
      `FESM_MARGIN_USER1: margin_level = FESM_LVL_ERASED;
      `FESM_MARGIN_USER0: margin_level = FESM_LVL_PROG;
      default:            margin_level = FESM_LVL_NORMAL;
    endcase
  endfunction

  assign cmd = w_reg[0][15:8];
  assign blk = w_reg[0][1:0];
  assign key_ok = {w_reg[1], w_reg[2], w_reg[3], w_reg[4]} == stored_key;

  // ====================================================
  // launch checks
  always_comb
  begin
    acc_err  = 1'b0;
    prot_err = 1'b0;
    if (!mode_allows_cmd)
      acc_err = 1'b1;
    case (cmd)
      `FESM_CMD_ERASE_SECTOR:
      begin
        if (index_reg != `FESM_IDX_1 || blk != `FESM_PBLOCK_SEL ||
            (w_reg[1] & `FESM_ALIGN_MASK) != 16'h0000)
          acc_err = 1'b1;
        if (sector_protected)
          prot_err = 1'b1;
      end
      `FESM_CMD_UNSECURE:
      begin
        if (index_reg != `FESM_IDX_0)
          acc_err = 1'b1;
        if (any_protected)
          prot_err = 1'b1;
      end
      `FESM_CMD_BACKDOOR:
      begin
        if (index_reg != `FESM_IDX_4 ||
            backdoor_key_enable_field != `FESM_KEY_ENABLED ||
            backdoor_locked || !key_ok)
          acc_err = 1'b1;
      end
      `FESM_CMD_USER_MARGIN:
      begin
        if (index_reg != `FESM_IDX_1 || blk > `FESM_DBLOCK_SEL ||
            !margin_valid(w_reg[1]))
          acc_err = 1'b1;
      end
      default: acc_err = 1'b1;
    endcase
  end

  // ====================================================
  // state machine
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg     <= FESM_IDLE;
      index_reg     <= 3'h0;
      rd_idx_reg    <= 3'h0;
      fetch_cnt_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        FESM_IDLE:
          if (launch && command_complete_flag)
          begin
            index_reg     <= command_object_index;
            rd_idx_reg    <= 3'h0;
            fetch_cnt_reg <= 3'h0;
            state_reg     <= FESM_FETCH;
          end
        FESM_FETCH:
        begin
          rd_idx_reg    <= rd_idx_reg + 3'h1;
          fetch_cnt_reg <= fetch_cnt_reg + 3'h1;
          if (fetch_cnt_reg == 3'h6)
            state_reg <= FESM_CHECK;
        end
        FESM_CHECK:
          if (acc_err || prot_err)
            state_reg <= FESM_DONE;
          else if (cmd == `FESM_CMD_ERASE_SECTOR ||
                   cmd == `FESM_CMD_UNSECURE)
            state_reg <= FESM_ARRAY;
          else
            state_reg <= FESM_DONE;
        FESM_ARRAY:
          if (array_resp.done)
            state_reg <= FESM_DONE;
        FESM_DONE:
          state_reg <= FESM_IDLE;
        default:
          state_reg <= FESM_IDLE;
      endcase
    end
  end

  // fetched words, one cycle behind the read index
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      armed_reg <= 1'b0;
      for (int i = 0; i < 6; i++)
        w_reg[i] <= 16'h0000;
    end
    else
    begin
      armed_reg <= (state_reg == FESM_FETCH);
      if (armed_reg && fetch_cnt_reg != 3'h0 && fetch_cnt_reg <= 3'h6)
        w_reg[fetch_cnt_reg - 3'h1] <= rd_data;
    end
  end

  // ====================================================
  // array request
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      array_req <= '0;
    else if (state_reg == FESM_CHECK && !acc_err && !prot_err)
    begin
      if (cmd == `FESM_CMD_ERASE_SECTOR)
        array_req <= '{FESM_OP_SECTOR, blk, w_reg[1]};
      else if (cmd == `FESM_CMD_UNSECURE)
        array_req <= '{FESM_OP_ALL, 2'h0, 16'h0000};
    end
    else if (state_reg == FESM_ARRAY && array_resp.done)
      array_req <= '0;
  end

  // ====================================================
  // command complete flag
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      command_complete_flag <= 1'b1;
    else if (state_reg == FESM_IDLE && launch && command_complete_flag)
      command_complete_flag <= 1'b0;
    else if (state_reg == FESM_DONE)
      command_complete_flag <= 1'b1;
  end

  // ====================================================
  // status bits
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      flash_status_reg <= '0;
    else if (state_reg == FESM_IDLE && launch && command_complete_flag)
      flash_status_reg <= '0;
    else if (state_reg == FESM_CHECK)
    begin
      flash_status_reg.access_error         <= acc_err;
      flash_status_reg.protection_violation <= prot_err;
    end
    else if (state_reg == FESM_ARRAY && array_resp.done)
    begin
      flash_status_reg.verify_bit1 <= array_resp.verify_fail;
      flash_status_reg.verify_bit0 <= array_resp.uncorrectable;
    end
  end

  // ====================================================
  // security and backdoor lockout
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      secured         <= 1'b1;
      backdoor_locked <= 1'b0;
    end
    else if (state_reg == FESM_FETCH && fetch_cnt_reg == 3'h0)
      secured <= secured & sync2_reg;
    else if (state_reg == FESM_CHECK && cmd == `FESM_CMD_BACKDOOR &&
             index_reg == `FESM_IDX_4 && mode_allows_cmd &&
             backdoor_key_enable_field == `FESM_KEY_ENABLED &&
             !backdoor_locked)
    begin
      if (key_ok)
        secured <= 1'b0;
      else
        backdoor_locked <= 1'b1;
    end
    else if (state_reg == FESM_ARRAY && array_resp.done &&
             array_req.op == FESM_OP_ALL && !array_resp.verify_fail)
      secured <= 1'b0;
  end

  // ====================================================
  // margin levels
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pflash_level <= FESM_LVL_NORMAL;
      dflash_level <= FESM_LVL_NORMAL;
    end
    else if (state_reg == FESM_CHECK && !acc_err &&
             cmd == `FESM_CMD_USER_MARGIN)
    begin
      if (blk == `FESM_PBLOCK_SEL)
      begin
        pflash_level <= margin_level(w_reg[1]);
        dflash_level <= margin_level(w_reg[1]);
      end
      else
        dflash_level <= margin_level(w_reg[1]);
    end
  end

  // ====================================================
  // checks
  sequence s_check_fail;
    state_reg == FESM_CHECK && (acc_err || prot_err);
  endsequence

  a_fail_skips_array: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_check_fail |=> state_reg == FESM_DONE ##1 command_complete_flag)
    else $error("failed check reached array");
  a_locked_refuses_key: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == FESM_CHECK && cmd == `FESM_CMD_BACKDOOR && backdoor_locked
    |=> flash_status_reg.access_error && $stable(secured))
    else $error("locked backdoor accepted");
  a_key_no_verify: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == FESM_CHECK && cmd == `FESM_CMD_BACKDOOR
    |=> !flash_status_reg.protection_violation &&
        !flash_status_reg.verify_bit1)
    else $error("backdoor set verify bits");
  a_unsecure_fail_keeps: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == FESM_ARRAY && array_resp.done && array_resp.verify_fail
    |=> flash_status_reg.verify_bit1 && secured == $past(secured))
    else $error("failed verify changed security");
  a_sector_index_err: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == FESM_CHECK && cmd == `FESM_CMD_ERASE_SECTOR &&
    index_reg != `FESM_IDX_1 |=> flash_status_reg.access_error)
    else $error("sector index not refused");
  a_unaligned_err: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == FESM_CHECK && cmd == `FESM_CMD_ERASE_SECTOR &&
    w_reg[1][2:0] != 3'h0 |=> state_reg == FESM_DONE)
    else $error("unaligned erase started");
  a_protect_viol: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == FESM_CHECK && cmd == `FESM_CMD_UNSECURE && any_protected
    |=> flash_status_reg.protection_violation)
    else $error("protection not flagged");
  a_mode_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
    state_reg == FESM_CHECK && !mode_allows_cmd
    |=> flash_status_reg.access_error ##1 command_complete_flag)
    else $error("mode not refused");
endmodule

//--- fesm_cfg.svh
// constants for the flash erase, security and margin command sequencer
`ifndef FESM_CFG_SVH
`define FESM_CFG_SVH
`define FESM_CMD_ERASE_SECTOR 8'h0A
`define FESM_CMD_UNSECURE     8'h0B
`define FESM_CMD_BACKDOOR     8'h0C
`define FESM_CMD_USER_MARGIN  8'h0D
`define FESM_IDX_0            3'h0
`define FESM_IDX_1            3'h1
`define FESM_IDX_4            3'h4
`define FESM_KEY_ENABLED      2'h2
`define FESM_MARGIN_NORMAL    16'h0000
`define FESM_MARGIN_USER1     16'h0001
`define FESM_MARGIN_USER0     16'h0002
`define FESM_PBLOCK_SEL       2'h0
`define FESM_DBLOCK_SEL       2'h1
`define FESM_KEY_ADDR         18'h3_FF00
`define FESM_ALIGN_MASK       16'h0007
`define FESM_RESP_TIMEOUT     16'h0100
`endif

//--- fesm_pkg.sv
// types for the flash erase, security and margin command sequencer
package fesm_pkg;
  typedef logic [15:0] fesm_word_t;
  typedef enum logic [1:0] {
    FESM_LVL_NORMAL = 2'h0,
    FESM_LVL_ERASED = 2'h1,
    FESM_LVL_PROG   = 2'h2
  } fesm_level_e;
  typedef enum logic [1:0] {
    FESM_OP_NONE   = 2'h0,
    FESM_OP_SECTOR = 2'h1,
    FESM_OP_ALL    = 2'h2
  } fesm_op_e;
  typedef struct packed {
    logic access_error;
    logic protection_violation;
    logic verify_bit1;
    logic verify_bit0;
  } fesm_status_s;
  typedef struct packed {
    fesm_op_e   op;
    logic [1:0] block;
    fesm_word_t addr;
  } fesm_array_req_s;
  typedef struct packed {
    logic done;
    logic verify_fail;
    logic uncorrectable;
  } fesm_array_resp_s;
endpackage

//--- fesm_param_mem.sv
// command object parameter store, six words, registered read
`timescale 1ns/1ps
module fesm_param_mem
  import fesm_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // write port
  input  wire logic              wr_en,
  input  wire logic [2:0]        wr_idx,
  input  wire fesm_pkg::fesm_word_t wr_data,
  // read port
  input  wire logic [2:0]        rd_idx,
  output fesm_pkg::fesm_word_t   rd_data
);
  fesm_word_t mem_reg [0:5];

  // storage
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 6; i++)
        mem_reg[i] <= 16'h0000;
    end
    else if (wr_en && wr_idx < 3'h6)
      mem_reg[wr_idx] <= wr_data;
  end

  // registered read
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rd_data <= 16'h0000;
    else
      rd_data <= (rd_idx < 3'h6) ? mem_reg[rd_idx] : 16'h0000;
  end
endmodule

//--- fesm_sequencer_tb.sv
// self-checking testbench for the flash command sequencer
`timescale 1ns/1ps
`include "fesm_cfg.svh"
module fesm_sequencer_tb;
  import fesm_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic             clk_sys = 1'b0;
  logic             rstn    = 1'b0;
  logic             param_wr = 1'b0;
  logic [2:0]       idx     = 3'h0;
  fesm_word_t       word    = 16'h0000;
  logic             launch  = 1'b0;
  logic             mode_ok = 1'b1;
  logic [1:0]       key_en  = 2'h2;
  logic [63:0]      key     = 64'h1111_2222_3333_4444;
  logic             sec_prot = 1'b0;
  logic             any_prot = 1'b0;
  fesm_array_resp_s resp    = '0;
  fesm_array_req_s  req;
  logic             complete;
  logic             secured;
  logic             locked;
  fesm_status_s     stat;
  fesm_level_e      plvl;
  fesm_level_e      dlvl;
  fesm_op_e         last_op;
  fesm_word_t       last_addr;
  fesm_word_t       pw [4];
  int               n_mismatch = 0;
  int               total_checks = 0;
  int               cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  fesm_sequencer uut (
    .clk_sys(clk_sys), .rstn(rstn), .param_wr(param_wr),
    .command_object_index(idx), .command_object_word(word),
    .launch(launch), .mode_allows_cmd(mode_ok),
    .backdoor_key_enable_field(key_en), .stored_key(key),
    .sector_protected(sec_prot), .any_protected(any_prot),
    .secure_at_reset(1'b1), .array_req(req), .array_resp(resp),
    .command_complete_flag(complete), .flash_status_reg(stat),
    .secured(secured), .backdoor_locked(locked),
    .pflash_level(plvl), .dflash_level(dlvl)
  );

  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] got);
    total_checks++;
    if (got !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic do_reset;
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
  endtask

  // load words, launch, act as array engine, wait for completion
  task automatic issue(input logic [7:0] cmd, input logic [1:0] blk,
                       input int nw, input logic [2:0] li,
                       input logic vf, input logic uc);
    bit sent;
    sent = 0;
    last_op = FESM_OP_NONE;
    last_addr = 16'h0000;
    for (int i = 0; i <= nw; i++)
    begin
      @(posedge clk_sys);
      param_wr <= 1'b1;
      idx <= i[2:0];
      word <= (i == 0) ? {cmd, 6'h00, blk} : pw[(i - 1) % 4];
    end
    @(posedge clk_sys);
    param_wr <= 1'b0;
    idx <= li;
    launch <= 1'b1;
    @(posedge clk_sys);
    launch <= 1'b0;
    for (int n = 0; n < 300; n++)
    begin
      @(posedge clk_sys);
      if (req.op != FESM_OP_NONE && !sent)
      begin
        last_op = req.op;
        last_addr = req.addr;
        resp <= '{1'b1, vf, uc};
        sent = 1;
      end
      else
        resp <= '0;
      if (n > 2 && complete === 1'b1)
        break;
    end
    chk("complete flag", 16'h0001, {15'h0000, complete});
  endtask

  task automatic sector(input logic [1:0] blk, input fesm_word_t a,
                        input logic [2:0] li, input logic pr,
                        input logic [1:0] vr, input logic [3:0] e);
    sec_prot <= pr;
    pw[0] = a;
    issue(`FESM_CMD_ERASE_SECTOR, blk, 1, li, vr[1], vr[0]);
    chk("sector status", e, stat);
    chk("sector op", (e[3:2] != 0) ? FESM_OP_NONE : FESM_OP_SECTOR,
        last_op);
    chk("sector addr", (e[3:2] != 0) ? 16'h0000 : a, last_addr);
  endtask

  // ==========================================
  // scenarios
  task automatic t_sector;
    sector(2'h0, 16'h1238, 3'h1, 0, 2'b00, 4'b0000);
    sector(2'h0, 16'h1238, 3'h1, 0, 2'b10, 4'b0010);
    sector(2'h0, 16'h1238, 3'h1, 0, 2'b11, 4'b0011);
    sector(2'h0, 16'h1238, 3'h0, 0, 2'b00, 4'b1000);
    sector(2'h1, 16'h1238, 3'h1, 0, 2'b00, 4'b1000);
    sector(2'h0, 16'h1234, 3'h1, 0, 2'b00, 4'b1000);
    sector(2'h0, 16'h1238, 3'h1, 1, 2'b00, 4'b0100);
    $display("sector erase done");
  endtask

  task automatic unsec(input logic [2:0] li, input logic pr,
                       input logic vf, input logic [3:0] e,
                       input logic sec_e);
    any_prot <= pr;
    issue(`FESM_CMD_UNSECURE, 2'h0, 0, li, vf, 1'b0);
    chk("unsecure status", e, stat);
    chk("unsecure secured", sec_e, secured);
  endtask

  task automatic t_unsecure;
    unsec(3'h1, 0, 0, 4'b1000, 1);
    unsec(3'h0, 1, 0, 4'b0100, 1);
    unsec(3'h0, 0, 1, 4'b0010, 1);
    unsec(3'h0, 0, 0, 4'b0000, 0);
    chk("unsecure op", FESM_OP_ALL, last_op);
    do_reset();
    $display("unsecure done");
  endtask

  task automatic bkd(input fesm_word_t k3, input logic [2:0] li,
                     input logic [3:0] e, input logic sec_e,
                     input logic lk_e);
    pw[0] = 16'h1111;
    pw[1] = 16'h2222;
    pw[2] = 16'h3333;
    pw[3] = k3;
    issue(`FESM_CMD_BACKDOOR, 2'h0, 4, li, 1'b1, 1'b1);
    chk("backdoor status", e, stat);
    chk("backdoor secured", sec_e, secured);
    chk("backdoor locked", lk_e, locked);
  endtask

  task automatic t_backdoor;
    key_en <= 2'h1;
    bkd(16'h4444, 3'h4, 4'b1000, 1, 0);
    key_en <= 2'h2;
    bkd(16'h4444, 3'h3, 4'b1000, 1, 0);
    bkd(16'h4445, 3'h4, 4'b1000, 1, 1);
    bkd(16'h4444, 3'h4, 4'b1000, 1, 1);
    do_reset();
    bkd(16'h4444, 3'h4, 4'b0000, 0, 0);
    chk("backdoor op", FESM_OP_NONE, last_op);
    do_reset();
    $display("backdoor done");
  endtask

  task automatic marg(input logic [1:0] blk, input fesm_word_t s,
                      input logic [2:0] li, input logic [3:0] e,
                      input fesm_level_e pe, input fesm_level_e de);
    pw[0] = s;
    issue(`FESM_CMD_USER_MARGIN, blk, 1, li, 1'b0, 1'b0);
    chk("margin status", e, stat);
    chk("margin plevel", pe, plvl);
    chk("margin dlevel", de, dlvl);
  endtask

  task automatic t_margin;
    marg(2'h1, 16'h0001, 3'h1, 0, FESM_LVL_NORMAL, FESM_LVL_ERASED);
    marg(2'h0, 16'h0002, 3'h1, 0, FESM_LVL_PROG, FESM_LVL_PROG);
    marg(2'h1, 16'h0000, 3'h1, 0, FESM_LVL_PROG, FESM_LVL_NORMAL);
    marg(2'h1, 16'h0003, 3'h1, 8, FESM_LVL_PROG, FESM_LVL_NORMAL);
    marg(2'h1, 16'h0001, 3'h0, 8, FESM_LVL_PROG, FESM_LVL_NORMAL);
    marg(2'h2, 16'h0001, 3'h1, 8, FESM_LVL_PROG, FESM_LVL_NORMAL);
    marg(2'h0, 16'h0000, 3'h1, 0, FESM_LVL_NORMAL, FESM_LVL_NORMAL);
    $display("user margin done");
  endtask

  task automatic t_mode;
    mode_ok <= 1'b0;
    sector(2'h0, 16'h1238, 3'h1, 0, 2'b00, 4'b1000);
    unsec(3'h0, 0, 0, 4'b1000, 1);
    bkd(16'h4444, 3'h4, 4'b1000, 1, 0);
    marg(2'h1, 16'h0001, 3'h1, 8, FESM_LVL_NORMAL, FESM_LVL_NORMAL);
    mode_ok <= 1'b1;
    $display("mode refusal done");
  endtask

  // ==========================================
  // timeout and main sequence
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    do_reset();
    t_mode();
    t_sector();
    t_margin();
    t_unsecure();
    t_backdoor();
    close_out();
  end
endmodule
